/* File: pkg/ipv6_acl_pkg.sv */
// ipv6_acl_pkg: constants and carriers for the ipv6/icmp match entry
// assumes one 125 MHz clock and an ahb-lite register bus of 32-bit words
//
// Contract
// - with next header selector any, the next header field never affects the match.
// - selector choices icmp, udp and tcp demand that protocol; only icmp also enables its own parameters.
// - with source selector any, the source address never affects the match.
// - source compare value and mask cover only the low 32 address bits.
// - source matches when low bits and mask equal configured address and mask; mask 0 is don't-care.
// - hop limit setting zero keeps frames with hop limit above zero from matching.
// - hop limit setting non-zero lets frames with hop limit above zero match.
// - hop limit setting any accepts every hop limit value.
// - with icmp type selector any, the icmp type never affects the match.
// - with icmp type selector specific, only frames whose icmp type equals the set value match.
// - icmp code selector any ignores the code; specific requires the code to equal the set value.
package ipv6_acl_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_NH_VALUE = 8'h04;
    localparam logic [7:0] OFS_SRC_ADDR = 8'h08;
    localparam logic [7:0] OFS_SRC_MASK = 8'h0C;
    localparam logic [7:0] OFS_ICMP     = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    localparam logic [7:0] OFS_HIT_CNT  = 8'h18;
    localparam logic [7:0] OFS_FRM_CNT  = 8'h1C;

    // control, icmp and status register fields
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_NH_LSB   = 4;
    localparam int CTRL_SRC_BIT  = 8;
    localparam int CTRL_HOP_LSB  = 12;
    localparam int CTRL_TYPE_BIT = 16;
    localparam int CTRL_CODE_BIT = 17;
    localparam int CTRL_CLR_BIT  = 31;
    localparam int ICMP_TYPE_LSB = 0;
    localparam int ICMP_CODE_LSB = 8;
    localparam int STAT_HIT_BIT  = 0;
    localparam int STAT_SEEN_BIT = 1;

    // reset values
    localparam logic [31:0] SRC_ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] SRC_MASK_RST = 32'hFFFF_FFFF;
    localparam logic [7:0]  VALUE_RST    = 8'h00;

    // selector encodings
    localparam logic [2:0] NH_ANY  = 3'h0;
    localparam logic [2:0] NH_SPEC = 3'h1;
    localparam logic [2:0] NH_ICMP = 3'h2;
    localparam logic [2:0] NH_UDP  = 3'h3;
    localparam logic [2:0] NH_TCP  = 3'h4;
    localparam logic [1:0] HOP_ANY     = 2'h0;
    localparam logic [1:0] HOP_ZERO    = 2'h1;
    localparam logic [1:0] HOP_NONZERO = 2'h2;

    // protocol numbers carried in the next header field
    localparam logic [7:0] PROTO_ICMP6 = 8'h3A;
    localparam logic [7:0] PROTO_UDP   = 8'h11;
    localparam logic [7:0] PROTO_TCP   = 8'h06;

    // parsed frame fields from the frame parser
    typedef struct packed {
        logic        is_ipv6;
        logic [7:0]  next_header;
        logic [31:0] src_low;
        logic [7:0]  hop_limit;
        logic [7:0]  icmp_type;
        logic [7:0]  icmp_code;
    } frame_s;

    // per-entry answer to the forwarding pipeline
    typedef struct packed {
        logic hit;
        logic nh_ok;
        logic src_ok;
        logic hop_ok;
        logic icmp_ok;
    } result_s;

endpackage

/* File: verilog/field_compare.sv */
// field_compare: any/specific equality test of one header field
// assumes selector and value are held stable by the register file
`timescale 1ns/10ps
module field_compare #(
    parameter int W = 8
) (
    // selector: 1 means specific
    input  wire logic         specific,
    // frame and configured values
    input  wire logic [W-1:0] field,
    input  wire logic [W-1:0] want,
    // result
    output logic              ok
);
    assign ok = !specific || (field == want);
endmodule

/* File: verilog/masked_compare.sv */
// masked_compare: masked equality test of a field, mask bit 0 is don't-care
// assumes pattern and mask are held stable by the register file
`timescale 1ns/10ps
module masked_compare #(
    parameter int W = 32
) (
    // selector: 1 means compare
    input  wire logic         enable,
    // frame value, configured pattern and mask
    input  wire logic [W-1:0] field,
    input  wire logic [W-1:0] pattern,
    input  wire logic [W-1:0] mask,
    // result
    output logic              ok
);
    assign ok = !enable || ((field & mask) == (pattern & mask));
endmodule

/* File: verilog/ipv6_icmp_acl_matcher.sv */
// ipv6_icmp_acl_matcher: one access_control_entry for ipv6 and icmp fields
// assumes frame fields come from a parser on mclk and an ahb-lite master
`timescale 1ns/10ps
module ipv6_icmp_acl_matcher
    import ipv6_acl_pkg::*;
#(
    parameter int CNT_W = 32
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // frame from parser
    input  wire logic        frame_valid,
    input  wire frame_s      frame,
    // match answer
    output logic             match_valid,
    output result_s          match
);

    // bus data phase
    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_WRITE = 2'b01,
        PH_READ  = 2'b10
    } bus_phase_e;

    // complete module state
    typedef struct packed {
        bus_phase_e       phase;
        logic [7:0]       waddr;
        logic [31:0]      rdata;
        logic             enable;
        logic [2:0]       nh_sel;
        logic [7:0]       nh_value;
        logic             src_sel;
        logic [31:0]      source_address_filter;
        logic [31:0]      source_address_mask;
        logic [1:0]       hop_sel;
        logic             type_sel;
        logic             code_sel;
        logic [7:0]       type_value;
        logic [7:0]       code_value;
        logic             res_valid;
        result_s          res;
        logic             seen;
        logic [CNT_W-1:0] hit_count;
        logic [CNT_W-1:0] frame_count;
    } state_s;

    localparam state_s STATE_RST = '{
        phase:                 PH_IDLE,
        waddr:                 8'h00,
        rdata:                 32'h0000_0000,
        enable:                1'b0,
        nh_sel:                NH_ANY,
        nh_value:              VALUE_RST,
        src_sel:               1'b0,
        source_address_filter: SRC_ADDR_RST,
        source_address_mask:   SRC_MASK_RST,
        hop_sel:               HOP_ANY,
        type_sel:              1'b0,
        code_sel:              1'b0,
        type_value:            VALUE_RST,
        code_value:            VALUE_RST,
        res_valid:             1'b0,
        res:                   '0,
        seen:                  1'b0,
        hit_count:             '0,
        frame_count:           '0
    };

    state_s      st_r;
    state_s      st_nxt;

    logic        take_addr;
    logic        clear_req;
    logic        icmp_mode;
    logic        nh_spec_ok;
    logic        nh_ok;
    logic        src_ok;
    logic        hop_ok;
    logic        type_ok;
    logic        code_ok;
    logic        icmp_ok;
    logic        hit;
    logic [31:0] read_word;
    logic [7:0]  raddr;
    logic        rd_take;
    logic        wr_phase;

    // counter bases
    logic [CNT_W-1:0] frame_base;
    logic [CNT_W-1:0] hit_base;

    // address phase accepted
    assign take_addr = hsel && hready && htrans[1];

    // read launch and write data phase
    assign rd_take  = take_addr && !hwrite;
    assign wr_phase = (st_r.phase == PH_WRITE);

    // word aligned register select, same decode for reads and writes
    assign raddr = {haddr[7:2], 2'b00};

    // icmp parameters only with icmp choice
    assign icmp_mode = (st_r.nh_sel == NH_ICMP);

    field_compare #(
        .W        (8)
    ) u_nh_cmp (
        .specific (1'b1),
        .field    (frame.next_header),
        .want     (st_r.nh_value),
        .ok       (nh_spec_ok)
    );

    masked_compare #(
        .W        (32)
    ) u_src_cmp (
        .enable   (st_r.src_sel),
        .field    (frame.src_low),
        .pattern  (st_r.source_address_filter),
        .mask     (st_r.source_address_mask),
        .ok       (src_ok)
    );

    field_compare #(
        .W        (8)
    ) u_type_cmp (
        .specific (st_r.type_sel && icmp_mode),
        .field    (frame.icmp_type),
        .want     (st_r.type_value),
        .ok       (type_ok)
    );

    field_compare #(
        .W        (8)
    ) u_code_cmp (
        .specific (st_r.code_sel && icmp_mode),
        .field    (frame.icmp_code),
        .want     (st_r.code_value),
        .ok       (code_ok)
    );

    assign icmp_ok = type_ok && code_ok;

    // next header selector decode
    always_comb begin
        unique case (st_r.nh_sel)
            NH_ANY: begin
                nh_ok = 1'b1;
            end
            NH_SPEC: begin
                nh_ok = nh_spec_ok;
            end
            NH_ICMP: begin
                nh_ok = (frame.next_header == PROTO_ICMP6);
            end
            NH_UDP: begin
                nh_ok = (frame.next_header == PROTO_UDP);
            end
            NH_TCP: begin
                nh_ok = (frame.next_header == PROTO_TCP);
            end
            default: begin
                nh_ok = 1'b0;
            end
        endcase
    end

    // hop limit selector decode
    always_comb begin
        unique case (st_r.hop_sel)
            HOP_ANY: begin
                hop_ok = 1'b1;
            end
            HOP_ZERO: begin
                hop_ok = (frame.hop_limit == 8'h00);
            end
            HOP_NONZERO: begin
                hop_ok = (frame.hop_limit != 8'h00);
            end
            default: begin
                hop_ok = 1'b0;
            end
        endcase
    end

    assign hit = st_r.enable && frame.is_ipv6 && nh_ok && src_ok && hop_ok && icmp_ok;

    // read mux
    always_comb begin
        read_word = 32'h0000_0000;
        unique case (raddr)
            OFS_CTRL: begin
                read_word[CTRL_EN_BIT]                 = st_r.enable;
                read_word[CTRL_NH_LSB +: 3]            = st_r.nh_sel;
                read_word[CTRL_SRC_BIT]                = st_r.src_sel;
                read_word[CTRL_HOP_LSB +: 2]           = st_r.hop_sel;
                read_word[CTRL_TYPE_BIT]               = st_r.type_sel;
                read_word[CTRL_CODE_BIT]               = st_r.code_sel;
            end
            OFS_NH_VALUE: begin
                read_word[7:0] = st_r.nh_value;
            end
            OFS_SRC_ADDR: begin
                read_word = st_r.source_address_filter;
            end
            OFS_SRC_MASK: begin
                read_word = st_r.source_address_mask;
            end
            OFS_ICMP: begin
                read_word[ICMP_TYPE_LSB +: 8] = st_r.type_value;
                read_word[ICMP_CODE_LSB +: 8] = st_r.code_value;
            end
            OFS_STATUS: begin
                read_word[STAT_HIT_BIT]  = st_r.res.hit;
                read_word[STAT_SEEN_BIT] = st_r.seen;
            end
            OFS_HIT_CNT: begin
                read_word[CNT_W-1:0] = st_r.hit_count;
            end
            OFS_FRM_CNT: begin
                read_word[CNT_W-1:0] = st_r.frame_count;
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    assign clear_req = wr_phase && (st_r.waddr == OFS_CTRL) && hwdata[CTRL_CLR_BIT];

    // counter bases, a clear in the same cycle restarts them
    assign frame_base = clear_req ? '0 : st_r.frame_count;
    assign hit_base   = clear_req ? '0 : st_r.hit_count;

    // next state
    always_comb begin
        st_nxt = st_r;

        // bus address phase, zero wait states
        if (take_addr) begin
            st_nxt.phase = hwrite ? PH_WRITE : PH_READ;
            st_nxt.waddr = raddr;
        end else if (hready) begin
            st_nxt.phase = PH_IDLE;
        end
        if (rd_take) begin
            st_nxt.rdata = read_word;
        end

        // bus data phase write
        if (wr_phase) begin
            unique case (st_r.waddr)
                OFS_CTRL: begin
                    st_nxt.enable   = hwdata[CTRL_EN_BIT];
                    st_nxt.nh_sel   = hwdata[CTRL_NH_LSB +: 3];
                    st_nxt.src_sel  = hwdata[CTRL_SRC_BIT];
                    st_nxt.hop_sel  = hwdata[CTRL_HOP_LSB +: 2];
                    st_nxt.type_sel = hwdata[CTRL_TYPE_BIT];
                    st_nxt.code_sel = hwdata[CTRL_CODE_BIT];
                end
                OFS_NH_VALUE: begin
                    st_nxt.nh_value = hwdata[7:0];
                end
                OFS_SRC_ADDR: begin
                    st_nxt.source_address_filter = hwdata;
                end
                OFS_SRC_MASK: begin
                    st_nxt.source_address_mask = hwdata;
                end
                OFS_ICMP: begin
                    st_nxt.type_value = hwdata[ICMP_TYPE_LSB +: 8];
                    st_nxt.code_value = hwdata[ICMP_CODE_LSB +: 8];
                end
                default: begin
                    st_nxt.enable = st_r.enable;
                end
            endcase
        end

        // counter clear, a frame in the same cycle still counts
        if (clear_req) begin
            st_nxt.seen        = 1'b0;
            st_nxt.hit_count   = '0;
            st_nxt.frame_count = '0;
        end

        st_nxt.res_valid = frame_valid;
        if (frame_valid) begin
            st_nxt.res.hit     = hit;
            st_nxt.res.nh_ok   = nh_ok;
            st_nxt.res.src_ok  = src_ok;
            st_nxt.res.hop_ok  = hop_ok;
            st_nxt.res.icmp_ok = icmp_ok;
            st_nxt.seen        = 1'b1;
            st_nxt.frame_count = frame_base + CNT_W'(1);
            if (hit) begin
                st_nxt.hit_count = hit_base + CNT_W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_r <= STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs
    assign hrdata      = st_r.rdata;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign match_valid = st_r.res_valid;
    assign match       = st_r.res;

endmodule

/* File: test/acl_rules_sva.sv */
// acl_rules_sva: port-level checks of one ipv6/icmp match entry
// assumes zero-wait ahb-lite writes and the package register map
`timescale 1ns/10ps
module acl_rules_sva
    import ipv6_acl_pkg::*;
#(
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rstn,
    // register writes
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    // frame and answer
    input wire logic        frame_valid,
    input wire frame_s      frame,
    input wire logic        match_valid,
    input wire result_s     match
);
    logic        wr_r;
    logic [7:0]  ofs_r;
    logic [31:0] ctrl_r, nhv_r, sa_r, sm_r, ic_r;
    logic        nh_e, src_e, hop_e, ic_e, hit_e;

    // shadow of the configuration, landing at the end of each write data phase
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_r   <= 1'b0;
            ofs_r  <= 8'h00;
            ctrl_r <= 32'h0000_0000;
            nhv_r  <= 32'h0000_0000;
            sa_r   <= SRC_ADDR_RST;
            sm_r   <= SRC_MASK_RST;
            ic_r   <= 32'h0000_0000;
        end else begin
            wr_r  <= hsel & hready & htrans[1] & hwrite;
            ofs_r <= haddr[7:0];
            if (wr_r && ofs_r == OFS_CTRL) ctrl_r <= hwdata;
            if (wr_r && ofs_r == OFS_NH_VALUE) nhv_r <= hwdata;
            if (wr_r && ofs_r == OFS_SRC_ADDR) sa_r <= hwdata;
            if (wr_r && ofs_r == OFS_SRC_MASK) sm_r <= hwdata;
            if (wr_r && ofs_r == OFS_ICMP) ic_r <= hwdata;
        end
    end

    // expected field results for the frame on the inputs
    always_comb begin
        case (ctrl_r[6:4])
            NH_ANY:  nh_e = 1'b1;
            NH_SPEC: nh_e = frame.next_header == nhv_r[7:0];
            NH_ICMP: nh_e = frame.next_header == PROTO_ICMP6;
            NH_UDP:  nh_e = frame.next_header == PROTO_UDP;
            NH_TCP:  nh_e = frame.next_header == PROTO_TCP;
            default: nh_e = 1'b0;
        endcase
        case (ctrl_r[13:12])
            HOP_ANY:     hop_e = 1'b1;
            HOP_ZERO:    hop_e = frame.hop_limit == 8'h00;
            HOP_NONZERO: hop_e = frame.hop_limit != 8'h00;
            default:     hop_e = 1'b0;
        endcase
        src_e = !ctrl_r[8] || ((frame.src_low ^ sa_r) & sm_r) == 32'h0000_0000;
        ic_e  = ctrl_r[6:4] != NH_ICMP
              || ((!ctrl_r[16] || frame.icmp_type == ic_r[7:0])
              && (!ctrl_r[17] || frame.icmp_code == ic_r[15:8]));
        hit_e = ctrl_r[0] & frame.is_ipv6 & nh_e & src_e & hop_e & ic_e;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_take;
        frame_valid;
    endsequence
    sequence s_answer;
        match_valid;
    endsequence

    property p_lat; s_take |=> s_answer; endproperty
    property p_lone; match_valid |-> $past(frame_valid); endproperty
    property p_hold; !frame_valid |=> $stable(match); endproperty
    property p_nh; s_take |=> match.nh_ok == $past(nh_e); endproperty
    property p_src; s_take |=> match.src_ok == $past(src_e); endproperty
    property p_hop; s_take |=> match.hop_ok == $past(hop_e); endproperty
    property p_icmp; s_take |=> match.icmp_ok == $past(ic_e); endproperty
    property p_hit; s_take |=> match.hit == $past(hit_e); endproperty

    a_lat: assert property (p_lat)
        else $error("no answer one cycle after a frame");
    a_lone: assert property (p_lone)
        else $error("answer without a frame");
    a_hold: assert property (p_hold)
        else $error("result changed without a frame");
    a_nh: assert property (p_nh)
        else $error("next header result wrong");
    a_src: assert property (p_src)
        else $error("source address result wrong");
    a_hop: assert property (p_hop)
        else $error("hop limit result wrong");
    a_icmp: assert property (p_icmp)
        else $error("icmp result wrong");
    a_hit: assert property (p_hit)
        else $error("hit result wrong");
endmodule

bind ipv6_icmp_acl_matcher acl_rules_sva #(.CNT_W(CNT_W)) u_sva (
    .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .frame_valid(frame_valid),
    .frame(frame), .match_valid(match_valid), .match(match));

/* File: test/frame_source.sv */
// frame_source: model of the frame parser feeding one match entry
// assumes the entry samples frame fields on the rising edge of mclk
`timescale 1ns/10ps
module frame_source
    import ipv6_acl_pkg::*;
(
    // clock
    input  wire logic mclk,
    // parsed frame out
    output logic      frame_valid,
    output frame_s    frame
);
    initial begin
        frame_valid = 1'b0;
        frame       = '0;
    end

    // one or two frames on consecutive cycles; idle fields are scrambled
    task automatic send(input frame_s f0, input frame_s f1, input int n);
        @(posedge mclk);
        frame_valid <= 1'b1;
        frame       <= f0;
        if (n == 2) begin
            @(posedge mclk);
            frame <= f1;
        end
        @(posedge mclk);
        frame_valid <= 1'b0;
        frame       <= ~frame;
    endtask
endmodule

/* File: test/ipv6_icmp_acl_matcher_test.sv */
// ipv6_icmp_acl_matcher_test: directed checks of one ipv6/icmp match entry
// assumes frame_source drives frames and acl_rules_sva is bound to the entry
`timescale 1ns/10ps
module ipv6_icmp_acl_matcher_test
    import ipv6_acl_pkg::*;
;
    logic        mclk, rstn, hsel, hwrite, hready, hreadyout, hresp;
    logic        frame_valid, match_valid;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    frame_s      frame;
    result_s     match;
    int          n_fail, comparisons;

    initial mclk = 1'b0;
    always #4 mclk = ~mclk;
    assign hready = hreadyout;

    frame_source u_src (.mclk(mclk), .frame_valid(frame_valid), .frame(frame));
    ipv6_icmp_acl_matcher uut (
        .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .frame_valid(frame_valid), .frame(frame), .match_valid(match_valid),
        .match(match));

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_rdy;
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk);
            if (hready === 1'b1) return;
        end
        n_fail++;
        complete_run();
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h00_0000, a};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0000_0000);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    function automatic frame_s mk(logic [7:0] nh, logic [31:0] s, logic [7:0] hop,
                                  logic [15:0] tc);
        return frame_s'({1'b1, nh, s, hop, tc});
    endfunction

    // sends one frame and compares {hit, nh, src, hop, icmp}
    task automatic frm(input frame_s f, input logic [4:0] exp);
        u_src.send(f, f, 1);
        #1;
        for (int i = 0; i < 8 && match_valid !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        if (match_valid !== 1'b1) begin
            n_fail++;
            complete_run();
        end
        chk({27'h0, match}, {27'h0, exp});
    endtask

    task automatic t_regs;
        rchk(OFS_CTRL, 32'h0000_0000);
        rchk(OFS_SRC_ADDR, SRC_ADDR_RST);
        rchk(OFS_SRC_MASK, SRC_MASK_RST);
        rchk(8'h40, 32'h0000_0000);
        bus(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
        rchk(OFS_STATUS, 32'h0000_0000);
        bus(1'b1, OFS_ICMP, 32'h0000_A5FF);
        rchk(OFS_ICMP, 32'h0000_A5FF);
        $display("test regs done");
    endtask

    task automatic t_nh;
        logic [7:0] udp, tcp, icm;
        udp = 8'h0B;
        tcp = 8'h11;
        icm = 8'h05;
        bus(1'b1, OFS_NH_VALUE, 32'h0000_0011);
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, OFS_CTRL, {25'h0, 3'(s), 4'h1});
            frm(mk(PROTO_UDP, 32'h0, 8'h1, 16'h0), {{2{udp[s]}}, 3'h7});
            frm(mk(PROTO_TCP, 32'h0, 8'h1, 16'h0), {{2{tcp[s]}}, 3'h7});
            frm(mk(PROTO_ICMP6, 32'h0, 8'h1, 16'h0), {{2{icm[s]}}, 3'h7});
        end
        $display("test next header done");
    endtask

    task automatic t_src;
        bus(1'b1, OFS_SRC_ADDR, 32'h0000_0003);
        bus(1'b1, OFS_SRC_MASK, 32'hFFFF_FFFE);
        bus(1'b1, OFS_CTRL, 32'h0000_0101);
        frm(mk(8'h0, 32'h0000_0002, 8'h1, 16'h0), 5'h1F);
        frm(mk(8'h0, 32'h0000_0003, 8'h1, 16'h0), 5'h1F);
        frm(mk(8'h0, 32'h0000_0001, 8'h1, 16'h0), 5'h0B);
        frm(mk(8'h0, 32'h8000_0003, 8'h1, 16'h0), 5'h0B);
        bus(1'b1, OFS_CTRL, 32'h0000_0001);
        frm(mk(8'h0, 32'h0000_0001, 8'h1, 16'h0), 5'h1F);
        $display("test source done");
    endtask

    task automatic t_hop;
        logic z, nz;
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, OFS_CTRL, {18'h0, 2'(m), 12'h001});
            z  = (m < 2);
            nz = (m == 0 || m == 2);
            frm(mk(8'h0, 32'h0, 8'h00, 16'h0), {z, 2'h3, z, 1'b1});
            frm(mk(8'h0, 32'h0, 8'hFF, 16'h0), {nz, 2'h3, nz, 1'b1});
        end
        $display("test hop limit done");
    endtask

    task automatic t_icmp;
        bus(1'b1, OFS_ICMP, 32'h0000_00FF);
        bus(1'b1, OFS_CTRL, 32'h0003_0021);
        frm(mk(PROTO_ICMP6, 32'h0, 8'h1, 16'hFF00), 5'h1F);
        frm(mk(PROTO_ICMP6, 32'h0, 8'h1, 16'hFE00), 5'h0E);
        frm(mk(PROTO_ICMP6, 32'h0, 8'h1, 16'hFF01), 5'h0E);
        bus(1'b1, OFS_CTRL, 32'h0002_0021);
        frm(mk(PROTO_ICMP6, 32'h0, 8'h1, 16'h0000), 5'h1F);
        frm(mk(PROTO_ICMP6, 32'h0, 8'h1, 16'h0001), 5'h0E);
        bus(1'b1, OFS_CTRL, 32'h0001_0021);
        frm(mk(PROTO_ICMP6, 32'h0, 8'h1, 16'hFF07), 5'h1F);
        $display("test icmp done");
    endtask

    task automatic t_hit;
        frame_s a, b;
        a = mk(8'h0, 32'h0, 8'h1, 16'h0);
        b = a;
        b.is_ipv6 = 1'b0;
        bus(1'b1, OFS_CTRL, 32'h8000_0001);
        u_src.send(a, b, 2);
        repeat (2) @(posedge mclk);
        chk({27'h0, match}, 32'h0000_000F);
        rchk(OFS_HIT_CNT, 32'h0000_0001);
        rchk(OFS_FRM_CNT, 32'h0000_0002);
        rchk(OFS_STATUS, 32'h0000_0002);
        bus(1'b1, OFS_CTRL, 32'h8000_0000);
        frm(a, 5'h0F);
        rchk(OFS_CTRL, 32'h0000_0000);
        rchk(OFS_HIT_CNT, 32'h0000_0000);
        $display("test hit done");
    endtask

    initial begin
        rstn        = 1'b0;
        hsel        = 1'b0;
        htrans      = 2'h0;
        hwrite      = 1'b0;
        haddr       = 32'h0000_0000;
        hwdata      = 32'h0000_0000;
        n_fail      = 0;
        comparisons = 0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        t_regs();
        t_nh();
        t_src();
        t_hop();
        t_icmp();
        t_hit();
        complete_run();
    end
endmodule
